// ### smbm_top.sv
// Sense multiplexer, selected-channel commands and switch bypass monitor
`timescale 1ns/1ps

// Functional notes
// - Route sense of exactly the one selected channel to the sense pin.
// - Selection codes 110 and 111 turn the sense output off.
// - Clear-latch command resets selected channel's restart counter and latches it off.
// - Slew-rate command changes slew setting of the selected channel only.
// - Restart counter read returns the selected channel's counter value.
// - Bypass monitor compares the selected channel's drain-source voltage to threshold.
// - Bypass comparison result is a readable bit of the diagnosis word.
// - In off state bypass result flags open load; host enables external pull-up.
// - Hard fault on the selected channel forces the sense output to high impedance.
module smbm_top #(
	parameter int NUM_CH = 6,
	parameter int CNT_W = 4,
	parameter int ADDR_W = 8
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_CH-1:0] chan_on,
	input wire logic [NUM_CH-1:0] hard_fault,
	input wire logic [NUM_CH-1:0] vds_above_threshold,
	input wire logic [NUM_CH*CNT_W-1:0] restart_count,
	output logic [NUM_CH-1:0] sense_route,
	output logic sense_output_enable,
	output logic [NUM_CH-1:0] counter_reset,
	output logic [NUM_CH-1:0] latch_off,
	output logic [NUM_CH-1:0] slew_change,
	output logic pullup_enable,
	output logic irq
);
	import smbm_pkg::*;

	// ==========================================================
	// Elaboration checks
	if (NUM_CH < 1 || NUM_CH > 6) begin : g_bad_ch
		$error("NUM_CH must be 1 to 6");
	end
	if (CNT_W < 1 || CNT_W > 32 || ADDR_W < 5 || ADDR_W > 32) begin : g_bad_w
		$error("CNT_W or ADDR_W out of range");
	end

	// ==========================================================
	// Helpers
	// A code names a channel only below the disable codes and below NUM_CH
	function automatic logic sel_valid(input logic [2:0] sel);
		sel_valid = (sel != SMBM_SEL_DISABLE_A) && (sel != SMBM_SEL_DISABLE_B)
			&& (int'(sel) < NUM_CH);
	endfunction

	function automatic logic [NUM_CH-1:0] chan_onehot(input logic [2:0] sel);
		logic [NUM_CH-1:0] v;
		v = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (int'(sel) == i) begin
				v[i] = 1'b1;
			end
		end
		chan_onehot = sel_valid(sel) ? v : '0;
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = ({{(32-ADDR_W){1'b0}}, a[ADDR_W-1:2], 2'b00} == {24'h0, off});
	endfunction

	// ==========================================================
	// State
	logic [2:0] sel_reg;
	logic pullup_reg;
	logic [SMBM_IRQ_W-1:0] irq_status_reg;
	logic [SMBM_IRQ_W-1:0] irq_mask_reg;
	logic [NUM_CH-1:0] sense_route_reg;
	logic bypass_flag_reg;
	logic open_load_reg;
	logic fault_reg;
	logic [NUM_CH-1:0] counter_reset_reg;
	logic [NUM_CH-1:0] latch_off_reg;
	logic [NUM_CH-1:0] slew_change_reg;
	smbm_wr_state_e wr_state_reg;
	logic aw_got_reg;
	logic w_got_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic w_lane0_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// Selected channel views
	logic sel_ok;
	logic [NUM_CH-1:0] sel_hot;
	logic sel_fault;
	logic sel_vds_above;
	logic sel_on;
	logic [CNT_W-1:0] sel_count;
	logic wr_commit;
	logic wr_mapped;
	logic wr_cmd;
	logic wr_lane;
	logic [SMBM_IRQ_W-1:0] irq_events;

	always_comb begin
		sel_ok = sel_valid(sel_reg);
		sel_hot = chan_onehot(sel_reg);
		sel_fault = |(sel_hot & hard_fault);
		sel_vds_above = |(sel_hot & vds_above_threshold);
		sel_on = |(sel_hot & chan_on);
		sel_count = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (sel_hot[i]) begin
				sel_count = restart_count[i*CNT_W +: CNT_W];
			end
		end
	end

	// ==========================================================
	// AXI4-Lite write path
	assign s_axi_awready = (wr_state_reg == SMBM_WR_COLLECT) && !aw_got_reg;
	assign s_axi_wready = (wr_state_reg == SMBM_WR_COLLECT) && !w_got_reg;
	assign s_axi_bvalid = (wr_state_reg == SMBM_WR_RESPOND);
	assign s_axi_bresp = bresp_reg;
	assign wr_commit = (wr_state_reg == SMBM_WR_COLLECT) && aw_got_reg && w_got_reg;
	assign wr_lane = wr_commit && w_lane0_reg;
	assign wr_cmd = wr_lane && hit(aw_addr_reg, SMBM_OFF_CMD);
	assign wr_mapped = hit(aw_addr_reg, SMBM_OFF_SELECT) || hit(aw_addr_reg, SMBM_OFF_CMD)
		|| hit(aw_addr_reg, SMBM_OFF_RESTART) || hit(aw_addr_reg, SMBM_OFF_DIAG)
		|| hit(aw_addr_reg, SMBM_OFF_IRQ_STATUS) || hit(aw_addr_reg, SMBM_OFF_IRQ_MASK);

	// Address and data are caught in either order, then answered together
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wr_state_reg <= SMBM_WR_COLLECT;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h0;
			w_lane0_reg <= 1'b0;
			bresp_reg <= SMBM_RESP_OKAY;
		end else begin
			case (wr_state_reg)
				SMBM_WR_COLLECT: begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_got_reg <= 1'b1;
						aw_addr_reg <= s_axi_awaddr;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_got_reg <= 1'b1;
						w_data_reg <= s_axi_wdata;
						w_lane0_reg <= s_axi_wstrb[0];
					end
					if (wr_commit) begin
						aw_got_reg <= 1'b0;
						w_got_reg <= 1'b0;
						bresp_reg <= wr_mapped ? SMBM_RESP_OKAY : SMBM_RESP_SLVERR;
						wr_state_reg <= SMBM_WR_RESPOND;
					end
				end
				SMBM_WR_RESPOND: begin
					if (s_axi_bready) begin
						wr_state_reg <= SMBM_WR_COLLECT;
					end
				end
				default: begin
					wr_state_reg <= SMBM_WR_COLLECT;
				end
			endcase
		end
	end

	// ==========================================================
	// Software registers; all fields live in byte lane 0
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sel_reg <= SMBM_SEL_RESET;
			pullup_reg <= 1'b0;
			irq_mask_reg <= SMBM_IRQ_MASK_RESET;
		end else if (wr_lane && hit(aw_addr_reg, SMBM_OFF_SELECT)) begin
			sel_reg <= w_data_reg[SMBM_SEL_LSB +: SMBM_SEL_W];
			pullup_reg <= w_data_reg[SMBM_PULLUP_BIT];
		end else if (wr_lane && hit(aw_addr_reg, SMBM_OFF_IRQ_MASK)) begin
			irq_mask_reg <= w_data_reg[SMBM_IRQ_W-1:0];
		end
	end

	// Command pulses reach only the selected channel; missing channels get none
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			counter_reset_reg <= '0;
			latch_off_reg <= '0;
			slew_change_reg <= '0;
		end else begin
			counter_reset_reg <= (wr_cmd && w_data_reg[SMBM_CMD_CLEAR_BIT]) ? sel_hot : '0;
			latch_off_reg <= (wr_cmd && w_data_reg[SMBM_CMD_CLEAR_BIT]) ? sel_hot : '0;
			slew_change_reg <= (wr_cmd && w_data_reg[SMBM_CMD_SLEW_BIT]) ? sel_hot : '0;
		end
	end

	// ==========================================================
	// Sense multiplexer and bypass monitor
	// Fault or disable code leaves the pin undriven, so only leakage remains
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sense_route_reg <= '0;
		end else begin
			sense_route_reg <= sel_fault ? '0 : sel_hot;
		end
	end

	// Comparator of the selected channel; reads zero with nothing selected
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			bypass_flag_reg <= 1'b0;
			open_load_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			bypass_flag_reg <= sel_vds_above;
			open_load_reg <= sel_ok && !sel_on && pullup_reg && !sel_vds_above;
			fault_reg <= sel_fault;
		end
	end

	// ==========================================================
	// Interrupts: rising events are sticky, write one clears, set wins
	assign irq_events = {(sel_ok && !sel_on && pullup_reg && !sel_vds_above && !open_load_reg),
		(sel_fault && !fault_reg)};

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			irq_status_reg <= '0;
		end else if (wr_lane && hit(aw_addr_reg, SMBM_OFF_IRQ_STATUS)) begin
			irq_status_reg <= (irq_status_reg & ~w_data_reg[SMBM_IRQ_W-1:0]) | irq_events;
		end else begin
			irq_status_reg <= irq_status_reg | irq_events;
		end
	end

	// ==========================================================
	// AXI4-Lite read path, one cycle from address to data
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= SMBM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= SMBM_RESP_OKAY;
			rdata_reg <= 32'h0;
			if (hit(s_axi_araddr, SMBM_OFF_SELECT)) begin
				rdata_reg[SMBM_SEL_LSB +: SMBM_SEL_W] <= sel_reg;
				rdata_reg[SMBM_PULLUP_BIT] <= pullup_reg;
			end else if (hit(s_axi_araddr, SMBM_OFF_RESTART)) begin
				rdata_reg[CNT_W-1:0] <= sel_count;
			end else if (hit(s_axi_araddr, SMBM_OFF_DIAG)) begin
				rdata_reg[SMBM_DIAG_BYPASS_BIT] <= bypass_flag_reg;
				rdata_reg[SMBM_DIAG_SENSE_BIT] <= |sense_route_reg;
				rdata_reg[SMBM_DIAG_OPEN_BIT] <= open_load_reg;
				rdata_reg[SMBM_DIAG_FAULT_BIT] <= fault_reg;
			end else if (hit(s_axi_araddr, SMBM_OFF_IRQ_STATUS)) begin
				rdata_reg[SMBM_IRQ_W-1:0] <= irq_status_reg;
			end else if (hit(s_axi_araddr, SMBM_OFF_IRQ_MASK)) begin
				rdata_reg[SMBM_IRQ_W-1:0] <= irq_mask_reg;
			end else if (!hit(s_axi_araddr, SMBM_OFF_CMD)) begin
				rresp_reg <= SMBM_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Outputs
	assign sense_route = sense_route_reg;
	assign sense_output_enable = |sense_route_reg;
	assign counter_reset = counter_reset_reg;
	assign latch_off = latch_off_reg;
	assign slew_change = slew_change_reg;
	assign pullup_enable = pullup_reg;
	assign irq = |(irq_status_reg & irq_mask_reg);

	// ==========================================================
	// Assertions
	property p_route_onehot;
		@(posedge clock) disable iff (!rst_b)
		$onehot0(sense_route_reg) && ((sense_route_reg & ~chan_onehot($past(sel_reg))) == '0);
	endproperty
	a_route_onehot: assert property (p_route_onehot) else $error("sense route wrong");
	property p_disable;
		@(posedge clock) disable iff (!rst_b)
		$past(rst_b) && (($past(sel_reg) == SMBM_SEL_DISABLE_A) ||
			($past(sel_reg) == SMBM_SEL_DISABLE_B)) |-> !sense_output_enable;
	endproperty
	a_disable: assert property (p_disable) else $error("sense on with disable code");
	property p_clear_latch;
		@(posedge clock) disable iff (!rst_b)
		wr_cmd && w_data_reg[SMBM_CMD_CLEAR_BIT] |=>
			counter_reset_reg == chan_onehot($past(sel_reg)) && latch_off_reg == counter_reset_reg
			##1 counter_reset_reg == '0 || $past(wr_cmd);
	endproperty
	a_clear_latch: assert property (p_clear_latch) else $error("clear latch pulse wrong");
	property p_slew;
		@(posedge clock) disable iff (!rst_b)
		slew_change_reg != '0 |-> $past(wr_cmd) && $onehot(slew_change_reg)
			&& slew_change_reg == chan_onehot($past(sel_reg));
	endproperty
	a_slew: assert property (p_slew) else $error("slew change not on selected channel");
	property p_restart_read;
		@(posedge clock) disable iff (!rst_b)
		s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, SMBM_OFF_RESTART) |=>
			s_axi_rvalid && s_axi_rdata == {{(32-CNT_W){1'b0}}, $past(sel_count)};
	endproperty
	a_restart_read: assert property (p_restart_read) else $error("restart read wrong");
	property p_bypass;
		@(posedge clock) disable iff (!rst_b)
		$past(rst_b) && sel_ok && $stable(sel_reg) && $stable(vds_above_threshold) |->
			bypass_flag_reg == vds_above_threshold[sel_reg];
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass flag mismatch");
	property p_diag_read;
		@(posedge clock) disable iff (!rst_b)
		s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, SMBM_OFF_DIAG) |=>
			s_axi_rdata[SMBM_DIAG_BYPASS_BIT] == $past(bypass_flag_reg) throughout s_axi_rvalid[*1];
	endproperty
	a_diag_read: assert property (p_diag_read) else $error("diag word bypass bit wrong");
	property p_open_load;
		@(posedge clock) disable iff (!rst_b)
		open_load_reg |-> $past(pullup_reg) && !$past(sel_on) && !$past(sel_vds_above);
	endproperty
	a_open_load: assert property (p_open_load) else $error("open load without cause");
	property p_fault_hiz;
		@(posedge clock) disable iff (!rst_b)
		sel_fault |=> !sense_output_enable;
	endproperty
	a_fault_hiz: assert property (p_fault_hiz) else $error("sense driven during fault");
	property p_missing_ch;
		@(posedge clock) disable iff (!rst_b)
		int'(sel_reg) >= NUM_CH |=> sense_route_reg == '0 && counter_reset_reg == '0
			&& slew_change_reg == '0;
	endproperty
	a_missing_ch: assert property (p_missing_ch) else $error("missing channel acted on");
	c_route: cover property (@(posedge clock) disable iff (!rst_b) sense_output_enable);
	c_clear: cover property (@(posedge clock) disable iff (!rst_b) counter_reset_reg != '0);
	c_open: cover property (@(posedge clock) disable iff (!rst_b) open_load_reg && irq);
endmodule

// ### smbm_pkg.sv
// Constants shared by the sense multiplexer and bypass monitor block
package smbm_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] SMBM_OFF_SELECT = 8'h00;
	localparam logic [7:0] SMBM_OFF_CMD = 8'h04;
	localparam logic [7:0] SMBM_OFF_RESTART = 8'h08;
	localparam logic [7:0] SMBM_OFF_DIAG = 8'h0c;
	localparam logic [7:0] SMBM_OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] SMBM_OFF_IRQ_MASK = 8'h14;
	// ==========================================================
	// Field positions
	localparam int SMBM_SEL_W = 3;
	localparam int SMBM_SEL_LSB = 0;
	localparam int SMBM_PULLUP_BIT = 4;
	localparam int SMBM_CMD_CLEAR_BIT = 0;
	localparam int SMBM_CMD_SLEW_BIT = 1;
	localparam int SMBM_DIAG_BYPASS_BIT = 0;
	localparam int SMBM_DIAG_SENSE_BIT = 1;
	localparam int SMBM_DIAG_OPEN_BIT = 2;
	localparam int SMBM_DIAG_FAULT_BIT = 3;
	localparam int SMBM_IRQ_FAULT_BIT = 0;
	localparam int SMBM_IRQ_OPEN_BIT = 1;
	localparam int SMBM_IRQ_W = 2;
	// ==========================================================
	// Selection codes and reset values
	localparam logic [2:0] SMBM_SEL_DISABLE_A = 3'h6;
	localparam logic [2:0] SMBM_SEL_DISABLE_B = 3'h7;
	localparam logic [2:0] SMBM_SEL_RESET = 3'h6;
	localparam logic [1:0] SMBM_IRQ_MASK_RESET = 2'h0;
	// ==========================================================
	// AXI responses
	localparam logic [1:0] SMBM_RESP_OKAY = 2'h0;
	localparam logic [1:0] SMBM_RESP_SLVERR = 2'h2;
	// ==========================================================
	// Sequencing of the write path
	typedef enum logic [1:0] {
		SMBM_WR_COLLECT = 2'b00,
		SMBM_WR_RESPOND = 2'b01
	} smbm_wr_state_e;
endpackage

// ### smbm_power_model.sv
// Behavioural model of the power stages behind the sense multiplexer
`timescale 1ns/1ps

module smbm_power_model #(
	parameter int N = 6,
	parameter int W = 4
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [N-1:0] on_req,
	input wire logic [N-1:0] fault_req,
	input wire logic [N-1:0] open_load,
	input wire logic [N-1:0] short_vs,
	input wire logic [N-1:0] counter_reset,
	input wire logic [N-1:0] latch_off,
	input wire logic [N-1:0] slew_change,
	input wire logic pullup_enable,
	output logic [N-1:0] chan_on,
	output logic [N-1:0] hard_fault,
	output logic [N-1:0] vds_above_threshold,
	output logic [N*W-1:0] restart_count,
	output logic [N-1:0] slew_fast
);
	// ==========================================================
	// Per-channel state
	logic [W-1:0] cnt [N];
	logic [N-1:0] latched;
	// Counters start distinct so a wrong read-back channel shows up
	always_ff @(posedge clock) begin
		for (int i = 0; i < N; i++) begin
			if (!rst_b) begin
				cnt[i] <= W'(i + 1);
			end else if (counter_reset[i]) begin
				cnt[i] <= '0;
			end
		end
	end
	// Latch and slew only act on the pulsed channel
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			latched <= '0;
			slew_fast <= '0;
		end else begin
			latched <= latched | latch_off;
			slew_fast <= slew_fast ^ slew_change;
		end
	end
	// Off stage: pull-up lifts an open output to battery, small drain-source drop
	always_comb begin
		chan_on = on_req & ~latched;
		hard_fault = fault_req;
		vds_above_threshold = ~chan_on & ~(short_vs | (open_load & {N{pullup_enable}}));
		for (int i = 0; i < N; i++) begin
			restart_count[i*W +: W] = cnt[i];
		end
	end
endmodule

// ### test_sense_mux_bypass_monitor.sv
// Register-level testbench of the sense multiplexer and bypass monitor
`timescale 1ns/1ps

module test_sense_mux_bypass_monitor;
	import smbm_pkg::*;
	// ==========================================================
	// Signals
	logic clock = 0, rst_b = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq, sense_oe, pullup_enable;
	logic [31:0] wdata = 0, rdata, rd;
	logic [3:0] wstrb = 0;
	logic [1:0] bresp, rresp, rs;
	logic [5:0] on_req = 0, fault_req = 0, open_load = 0, short_vs = 0;
	logic [5:0] chan_on, hard_fault, vds, sense_route, c_rst, l_off, s_chg, slew_fast;
	logic [23:0] r_cnt;
	int n_fail = 0, cmp_count = 0;
	// ==========================================================
	// Design, power stage model, clock
	smbm_top #(.NUM_CH(6), .CNT_W(4), .ADDR_W(8)) smbm_top_inst (.clock(clock), .rst_b(rst_b),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.chan_on(chan_on), .hard_fault(hard_fault), .vds_above_threshold(vds),
		.restart_count(r_cnt), .sense_route(sense_route), .sense_output_enable(sense_oe),
		.counter_reset(c_rst), .latch_off(l_off), .slew_change(s_chg),
		.pullup_enable(pullup_enable), .irq(irq));
	smbm_power_model #(.N(6), .W(4)) smbm_power_model_inst (.clock(clock), .rst_b(rst_b),
		.on_req(on_req), .fault_req(fault_req), .open_load(open_load), .short_vs(short_vs),
		.counter_reset(c_rst), .latch_off(l_off), .slew_change(s_chg),
		.pullup_enable(pullup_enable), .chan_on(chan_on), .hard_fault(hard_fault),
		.vds_above_threshold(vds), .restart_count(r_cnt), .slew_fast(slew_fast));
	initial begin
		forever #12.5 clock = ~clock;
	end
	// ==========================================================
	// Bus tasks and comparison
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!done) begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) begin
				r = bresp;
				bready <= 0;
				done = 1;
			end
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!done) begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 0;
				done = 1;
			end
		end
	endtask
	// Let launched updates land before looking at outputs
	task automatic settle();
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Watchdog, well beyond the expected run
	initial begin
		#(25 * 20000);
		n_fail++;
		summarize();
	end
	// ==========================================================
	// Test sequence
	initial begin
		repeat (12) @(posedge clock);
		rst_b <= 1;
		axi_rd(SMBM_OFF_SELECT, rd, rs);
		chk("select reset", 32'h6, rd);
		axi_rd(SMBM_OFF_IRQ_MASK, rd, rs);
		chk("mask reset", 32'h0, rd);
		// Every selection code: route, read-back and bypass flag
		short_vs <= 6'h0a;
		for (int s = 0; s < 8; s++) begin
			axi_wr(SMBM_OFF_SELECT, 32'(s), rs);
			chk("select resp", SMBM_RESP_OKAY, rs);
			settle();
			chk("route", s < 6 ? 32'(1 << s) : 0, sense_route);
			chk("sense enable", s < 6, sense_oe);
			axi_rd(SMBM_OFF_RESTART, rd, rs);
			chk("restart", s < 6 ? 32'(s + 1) : 0, rd);
			axi_rd(SMBM_OFF_DIAG, rd, rs);
			chk("bypass", s < 6 ? 32'(!short_vs[s % 6]) : 0, rd[0]);
		end
		// Clear latch on channel 2 only
		on_req <= 6'h3f;
		axi_wr(SMBM_OFF_SELECT, 32'h2, rs);
		axi_wr(SMBM_OFF_CMD, 32'h1, rs);
		settle();
		chk("latched", 32'h3b, chan_on);
		chk("count3", 32'h4, smbm_power_model_inst.cnt[3]);
		axi_rd(SMBM_OFF_RESTART, rd, rs);
		chk("restart cleared", 32'h0, rd);
		// Slew change on channel 4, then none while disabled
		axi_wr(SMBM_OFF_SELECT, 32'h4, rs);
		axi_wr(SMBM_OFF_CMD, 32'h2, rs);
		axi_wr(SMBM_OFF_SELECT, 32'h6, rs);
		axi_wr(SMBM_OFF_CMD, 32'h3, rs);
		settle();
		chk("slew", 32'h10, slew_fast);
		chk("no latch", 32'h3b, chan_on);
		// Hard fault on selected channel, interrupt masked and cleared
		axi_wr(SMBM_OFF_IRQ_MASK, 32'h3, rs);
		axi_wr(SMBM_OFF_SELECT, 32'h1, rs);
		fault_req <= 6'h02;
		settle();
		chk("fault route", 32'h0, sense_route);
		chk("irq", 32'h1, irq);
		axi_rd(SMBM_OFF_DIAG, rd, rs);
		chk("diag fault", 32'h1, rd[SMBM_DIAG_FAULT_BIT]);
		fault_req <= 0;
		axi_wr(SMBM_OFF_IRQ_MASK, 32'h0, rs);
		#1 chk("irq masked", 32'h0, irq);
		axi_wr(SMBM_OFF_IRQ_MASK, 32'h1, rs);
		#1 chk("irq unmasked", 32'h1, irq);
		axi_wr(SMBM_OFF_IRQ_STATUS, 32'h3, rs);
		#1 chk("irq cleared", 32'h0, irq);
		axi_rd(SMBM_OFF_IRQ_STATUS, rd, rs);
		chk("status cleared", 32'h0, rd);
		// Open load in off state needs the pull-up
		on_req <= 0;
		short_vs <= 0;
		open_load <= 6'h08;
		axi_wr(SMBM_OFF_SELECT, 32'h13, rs);
		settle();
		chk("pullup", 32'h1, pullup_enable);
		axi_rd(SMBM_OFF_DIAG, rd, rs);
		chk("open diag", 32'h6, rd[3:0]);
		axi_rd(SMBM_OFF_IRQ_STATUS, rd, rs);
		chk("open status", 32'h2, rd);
		axi_wr(SMBM_OFF_IRQ_MASK, 32'h2, rs);
		#1 chk("open irq", 32'h1, irq);
		axi_wr(SMBM_OFF_SELECT, 32'h03, rs);
		settle();
		axi_rd(SMBM_OFF_DIAG, rd, rs);
		chk("no pullup diag", 32'h3, rd[3:0]);
		// Unmapped address
		axi_rd(8'h20, rd, rs);
		chk("unmapped rresp", SMBM_RESP_SLVERR, rs);
		chk("unmapped data", 32'h0, rd);
		axi_wr(8'h20, 32'h1, rs);
		chk("unmapped bresp", SMBM_RESP_SLVERR, rs);
		// Command register is write-only and reads back as zero
		axi_rd(SMBM_OFF_CMD, rd, rs);
		chk("cmd read resp", SMBM_RESP_OKAY, rs);
		chk("cmd read data", 32'h0, rd);
		summarize();
	end
endmodule
